// ===== design/pgls_pkg.sv
// package for the power-good and load-switch control block
`default_nettype none
package pgls_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MON_START_US = 5_000;
  localparam int unsigned MON_START_CYC = (MON_START_US * (CLK_HZ / 1_000_000));
  localparam int unsigned STROBE_EXTRA_US = 1_000;
  localparam int unsigned STROBE_EXTRA_CYC = (STROBE_EXTRA_US * (CLK_HZ / 1_000_000));
  localparam int unsigned UV_DEGLITCH_LOOSE_US = 1_000;
  localparam int unsigned UV_DEGLITCH_LOOSE_CYC = (UV_DEGLITCH_LOOSE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned UV_DEGLITCH_TIGHT_US = 50;
  localparam int unsigned UV_DEGLITCH_TIGHT_CYC = (UV_DEGLITCH_TIGHT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned DIP_WINDOW_US = 5_000;
  localparam int unsigned DIP_WINDOW_CYC = (DIP_WINDOW_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RELEASE_UNIT_US = 1_000;
  localparam int unsigned RELEASE_UNIT_CYC = (RELEASE_UNIT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RAILS = 5;
  // register byte offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_SWCFG = 8'h04;
  localparam logic [7:0] OFF_SUPCFG = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  // field positions in ENABLE: rails [4:0], switches [10:8]
  localparam int unsigned POS_RAIL_EN = 0;
  localparam int unsigned POS_SW_EN = 8;
  // field positions in SWCFG
  localparam int unsigned POS_DCHG = 0;
  localparam int unsigned POS_SHED = 4;
  localparam int unsigned POS_LIM2 = 8;
  localparam int unsigned POS_LIM3 = 10;
  // field positions in SUPCFG
  localparam int unsigned POS_TIGHT = 0;
  localparam int unsigned POS_DELAY = 4;
  // field positions in IRQ: overcurrent [2:0], fault [6:4]
  localparam int unsigned POS_OC = 0;
  localparam int unsigned POS_FLT = 4;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_SWCFG = 32'h0000_0000;
  localparam logic [31:0] RST_SUPCFG = 32'h0000_0010;
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;
  typedef struct packed {
    logic [2:0] on;
    logic [2:0] discharge;
  } pgls_sw_out_type;
  typedef struct packed {
    logic [2:0] limiting;
    logic [2:0] overtemp;
    logic in_low;
  } pgls_sw_in_type;
endpackage : pgls_pkg
`default_nettype wire

// ===== design/pgls_ctrl.sv
// power-good supervision and load switch control with wishbone registers
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`default_nettype none
module pgls_ctrl #(
  parameter int unsigned MON_START = pgls_pkg::MON_START_CYC,
  parameter int unsigned STROBE_EXTRA = pgls_pkg::STROBE_EXTRA_CYC,
  parameter int unsigned UV_LOOSE = pgls_pkg::UV_DEGLITCH_LOOSE_CYC,
  parameter int unsigned DIP_WINDOW = pgls_pkg::DIP_WINDOW_CYC,
  parameter int unsigned RELEASE_UNIT = pgls_pkg::RELEASE_UNIT_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [4:0] RAIL_UV,
  input wire logic [4:0] RAIL_OV,
  input wire logic BACKUP_A_GOOD,
  input wire logic BACKUP_B_GOOD,
  input wire logic [2:0] SW_LIMITING,
  input wire logic [2:0] SW_OVERTEMP,
  input wire logic SW2_IN_LOW,
  input wire logic POWERFAIL_TRIP,
  input wire logic UVLO_TRIP,
  input wire logic BIAS_LOW,
  input wire logic SEQ_DONE,
  input wire logic SEQ_RAIL_STROBE,
  input wire logic SEQ_RAIL_EN,
  input wire logic SEQ_SW1_EN,
  input wire logic SEQ_SW1_STROBE,
  input wire logic SUSPEND_STATE,
  output logic MAIN_POWER_GOOD,
  output logic BACKUP_POWER_GOOD,
  output logic POWER_DOWN_REQ,
  output logic CORE_RESET,
  output logic SEQ_STROBE_READY,
  output logic [4:0] RAIL_EN,
  output logic [4:0] RAIL_DISCHARGE,
  output logic [2:0] SW_ON,
  output logic [2:0] SW_DISCHARGE,
  output logic [1:0] SW2_LIMIT,
  output logic [1:0] SW3_LIMIT
);
  // counts at 10 MHz exceed 4096, so held as 32-bit counters, the release counter as 36-bit
  typedef enum logic [2:0] {
    PGLS_OFF_STATE = 3'b001,
    PGLS_DELAY_STATE = 3'b010,
    PGLS_GOOD_STATE = 3'b100
  } pgls_state_type;

  // two-flop synchronisers for everything analog or from the pins
  // a pin moving near the edge may leave the first stage metastable;
  // only the second stage is read, so logic sees one settled level
  // every pin shares the same two-cycle latency
  logic [21:0] sync1_reg;
  logic [21:0] sync2_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {RAIL_UV, RAIL_OV, BACKUP_A_GOOD, BACKUP_B_GOOD, SW_LIMITING, SW_OVERTEMP,
                    SW2_IN_LOW, POWERFAIL_TRIP, UVLO_TRIP, BIAS_LOW};
      sync2_reg <= sync1_reg;
    end
  end
  logic [4:0] uv_s;
  logic [4:0] ov_s;
  logic bua_s;
  logic bub_s;
  logic [2:0] lim_s;
  logic [2:0] ot_s;
  logic in_low_s;
  logic pf_s;
  logic uvlo_s;
  logic bias_s;
  assign {uv_s, ov_s, bua_s, bub_s, lim_s, ot_s, in_low_s, pf_s, uvlo_s, bias_s} = sync2_reg;

  // registers
  logic [4:0] rail_en_reg;
  logic [2:0] sw_en_reg;
  logic [2:0] dchg_reg;
  logic [2:0] shed_reg;
  logic [1:0] lim2_reg;
  logic [1:0] lim3_reg;
  logic tight_reg;
  logic [3:0] delay_reg;
  logic [2:0] oc_irq_reg;
  logic [2:0] flt_irq_reg;
  // power-down latch and main good state feed the status word,
  // so they are declared ahead of the bus answer
  logic pwr_down_reg;
  pgls_state_type state_reg;
  pgls_state_type state_next;
  logic wr_en;
  logic rd_en;
  assign wr_en = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
  assign rd_en = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // wishbone answer: ack one cycle after strobe, dropped the next
  // the ack gate on wr_en and rd_en stops a held request acting twice
  // status reads show outputs one cycle old, invisible to software
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      if (rd_en) begin
        unique case (WB_ADR_I)
          pgls_pkg::OFF_ENABLE: WB_DAT_O <= {21'h0, sw_en_reg, 3'h0, rail_en_reg};
          pgls_pkg::OFF_SWCFG: WB_DAT_O <= {20'h0, lim3_reg, lim2_reg, 1'b0, shed_reg, 1'b0, dchg_reg};
          pgls_pkg::OFF_SUPCFG: WB_DAT_O <= {24'h0, delay_reg, 3'h0, tight_reg};
          pgls_pkg::OFF_STATUS: WB_DAT_O <= {26'h0, pwr_down_reg, BACKUP_POWER_GOOD, MAIN_POWER_GOOD,
                                             (state_reg == PGLS_GOOD_STATE), in_low_s, pf_s};
          pgls_pkg::OFF_IRQ: WB_DAT_O <= {25'h0, flt_irq_reg, 1'b0, oc_irq_reg};
          default: WB_DAT_O <= pgls_pkg::BAD_ADDR_DATA;
        endcase
      end
    end
  end

  // software and sequencer writes to enables; hardware clears win over both
  // a later assignment in this process wins over an earlier one,
  // so powerfail shedding overrides both the bus and the sequencer
  // limitation: a bus write to enables during a sequencer rail strobe is lost
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rail_en_reg <= pgls_pkg::RST_ENABLE[4:0];
      sw_en_reg <= pgls_pkg::RST_ENABLE[10:8];
    end else if (bias_s) begin
      rail_en_reg <= '0;
      sw_en_reg <= '0;
    end else begin
      if (wr_en && hit(WB_ADR_I, pgls_pkg::OFF_ENABLE) && !SEQ_RAIL_STROBE) begin
        rail_en_reg <= WB_DAT_I[pgls_pkg::POS_RAIL_EN +: 5];
        sw_en_reg <= WB_DAT_I[pgls_pkg::POS_SW_EN +: 3];
      end
      if (SEQ_RAIL_STROBE) begin
        rail_en_reg <= SEQ_RAIL_EN ? (rail_en_reg | next_rail(rail_en_reg)) : 5'h0_0;
      end
      if (SEQ_SW1_STROBE) begin
        sw_en_reg[0] <= SEQ_SW1_EN;
      end
      // only shed switches drop, and stay off until rewritten
      if (pf_s) begin
        sw_en_reg <= sw_en_reg & ~shed_reg;
      end
    end
  end

  // sequencer enables lowest still-off rail on each strobe with SEQ_RAIL_EN set; a strobe with it clear turns all rails off
  function automatic logic [4:0] next_rail(input logic [4:0] en);
    next_rail = (~en) & (en + 5'h0_1);
  endfunction

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dchg_reg <= pgls_pkg::RST_SWCFG[2:0];
      shed_reg <= pgls_pkg::RST_SWCFG[6:4];
      lim2_reg <= pgls_pkg::RST_SWCFG[9:8];
      lim3_reg <= pgls_pkg::RST_SWCFG[11:10];
      tight_reg <= pgls_pkg::RST_SUPCFG[0];
      delay_reg <= pgls_pkg::RST_SUPCFG[7:4];
    end else if (wr_en && hit(WB_ADR_I, pgls_pkg::OFF_SWCFG)) begin
      dchg_reg <= WB_DAT_I[pgls_pkg::POS_DCHG +: 3];
      shed_reg <= WB_DAT_I[pgls_pkg::POS_SHED +: 3];
      lim2_reg <= WB_DAT_I[pgls_pkg::POS_LIM2 +: 2];
      lim3_reg <= WB_DAT_I[pgls_pkg::POS_LIM3 +: 2];
    end else if (wr_en && hit(WB_ADR_I, pgls_pkg::OFF_SUPCFG)) begin
      tight_reg <= WB_DAT_I[pgls_pkg::POS_TIGHT];
      delay_reg <= WB_DAT_I[pgls_pkg::POS_DELAY +: 4];
    end
  end

  // switch fault sources: overtemperature, and input low for the five-volt one
  logic [2:0] sw_held;
  assign sw_held = ot_s | {1'b0, in_low_s, 1'b0};

  // sticky flags, write one to clear, set wins over clear
  // a clear landing with a new event leaves the flag set,
  // so software never loses an event it has not yet seen
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      oc_irq_reg <= '0;
      flt_irq_reg <= '0;
    end else begin
      logic [2:0] oc_clr;
      logic [2:0] flt_clr;
      oc_clr = (wr_en && hit(WB_ADR_I, pgls_pkg::OFF_IRQ)) ? WB_DAT_I[pgls_pkg::POS_OC +: 3] : 3'h0;
      flt_clr = (wr_en && hit(WB_ADR_I, pgls_pkg::OFF_IRQ)) ? WB_DAT_I[pgls_pkg::POS_FLT +: 3] : 3'h0;
      oc_irq_reg <= (oc_irq_reg & ~oc_clr) | (lim_s & sw_en_reg);
      flt_irq_reg <= (flt_irq_reg & ~flt_clr) | (sw_held & sw_en_reg);
    end
  end

  // switch drive; limiting switch stays on
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      SW_ON <= '0;
      SW_DISCHARGE <= '0;
      SW2_LIMIT <= '0;
      SW3_LIMIT <= '0;
    end else begin
      SW_ON <= sw_en_reg & ~sw_held;
      SW_DISCHARGE <= dchg_reg & ~(sw_en_reg & ~sw_held);
      SW2_LIMIT <= lim2_reg;
      SW3_LIMIT <= lim3_reg;
    end
  end

  // per-rail start-up mask and fault deglitch counters
  // counters saturate at their limit rather than wrap, so a long
  // excursion cannot roll over and look like a recovery
  // trade-off: wide counters per rail cost area but fit any parameter
  logic [31:0] mon_cnt_reg [pgls_pkg::RAILS];
  logic [31:0] dg_cnt_reg [pgls_pkg::RAILS];
  logic [4:0] monitored;
  logic [4:0] rail_fault;
  logic [31:0] dg_limit;
  assign dg_limit = tight_reg ? pgls_pkg::UV_DEGLITCH_TIGHT_CYC : UV_LOOSE;
  for (genvar i = 0; i < pgls_pkg::RAILS; i++) begin : g_rail
    logic out_of_range;
    assign out_of_range = uv_s[i] | (tight_reg & ov_s[i]);
    assign monitored[i] = rail_en_reg[i] && (mon_cnt_reg[i] >= MON_START);
    assign rail_fault[i] = monitored[i] && (dg_cnt_reg[i] >= dg_limit);
    always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
        mon_cnt_reg[i] <= '0;
        dg_cnt_reg[i] <= '0;
      end else begin
        if (!rail_en_reg[i]) begin
          mon_cnt_reg[i] <= '0;
        end else if (mon_cnt_reg[i] < MON_START) begin
          mon_cnt_reg[i] <= mon_cnt_reg[i] + 32'h0000_0001;
        end
        if (!monitored[i] || !out_of_range) begin
          dg_cnt_reg[i] <= '0;
        end else if (dg_cnt_reg[i] < dg_limit) begin
          dg_cnt_reg[i] <= dg_cnt_reg[i] + 32'h0000_0001;
        end
      end
    end
  end

  // lockout dip: shut down only if input stays low 5 ms
  // a dip shorter than the window leaves no trace; the count
  // restarts from zero on every recovery
  logic [31:0] dip_cnt_reg;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      dip_cnt_reg <= '0;
    end else if (!uvlo_s) begin
      dip_cnt_reg <= '0;
    end else if (dip_cnt_reg < DIP_WINDOW) begin
      dip_cnt_reg <= dip_cnt_reg + 32'h0000_0001;
    end
  end

  // power-down request from rail fault, lockout or bias loss; powerfail is not tied in here
  logic pd_cause;
  assign pd_cause = (|rail_fault) || (dip_cnt_reg >= DIP_WINDOW) || bias_s;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pwr_down_reg <= 1'b0;
    end else if (pd_cause) begin
      pwr_down_reg <= 1'b1;
    end else if (rail_en_reg == 5'h0_0) begin
      pwr_down_reg <= 1'b0;
    end
  end

  // strobe wait: rail good, then the extra 1 ms, before next strobe
  // ready is withheld while any enabled rail is under its threshold,
  // so a slow rail stretches the sequence instead of being skipped
  logic [31:0] strobe_cnt_reg;
  logic last_good;
  assign last_good = ((rail_en_reg & uv_s) == 5'h0_0);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strobe_cnt_reg <= '0;
    end else if (SEQ_RAIL_STROBE || !last_good) begin
      strobe_cnt_reg <= '0;
    end else if (strobe_cnt_reg < STROBE_EXTRA) begin
      strobe_cnt_reg <= strobe_cnt_reg + 32'h0000_0001;
    end
  end

  // main good state machine
  // good is registered from the next state, so it drops at the same
  // edge as the state and shows no stale cycle of good
  logic [35:0] rel_cnt_reg;
  logic force_low;
  assign force_low = (rail_en_reg == 5'h0_0) || pwr_down_reg || pd_cause || SUSPEND_STATE;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PGLS_OFF_STATE: if (!force_low && SEQ_DONE) state_next = PGLS_DELAY_STATE;
      PGLS_DELAY_STATE: begin
        if (force_low) state_next = PGLS_OFF_STATE;
        else if (rel_cnt_reg >= 36'(delay_reg) * 36'(RELEASE_UNIT)) state_next = PGLS_GOOD_STATE;
      end
      PGLS_GOOD_STATE: if (force_low) state_next = PGLS_OFF_STATE;
      default: state_next = PGLS_OFF_STATE;
    endcase
  end
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= PGLS_OFF_STATE;
      rel_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      rel_cnt_reg <= (state_reg == PGLS_DELAY_STATE) ? rel_cnt_reg + 36'h0_0000_0001 : 36'h0_0000_0000;
    end
  end

  // outputs; backup good is a plain and, isolated from the rest
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      MAIN_POWER_GOOD <= 1'b0;
      BACKUP_POWER_GOOD <= 1'b0;
      POWER_DOWN_REQ <= 1'b0;
      CORE_RESET <= 1'b0;
      SEQ_STROBE_READY <= 1'b0;
      RAIL_EN <= '0;
      RAIL_DISCHARGE <= '0;
    end else begin
      MAIN_POWER_GOOD <= (state_next == PGLS_GOOD_STATE);
      BACKUP_POWER_GOOD <= bua_s & bub_s;
      POWER_DOWN_REQ <= pwr_down_reg | pd_cause;
      CORE_RESET <= bias_s;
      SEQ_STROBE_READY <= last_good && (strobe_cnt_reg >= STROBE_EXTRA);
      RAIL_EN <= rail_en_reg;
      RAIL_DISCHARGE <= bias_s ? 5'h1_F : ~rail_en_reg;
    end
  end
endmodule // pgls_ctrl
`default_nettype wire

// ===== test/pgls_ctrl_checker.sv
// concurrent checks on the ports of the power-good and load switch block
`default_nettype none
module pgls_ctrl_checker (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic BACKUP_A_GOOD,
  input wire logic BACKUP_B_GOOD,
  input wire logic BIAS_LOW,
  input wire logic [2:0] SW_OVERTEMP,
  input wire logic SW2_IN_LOW,
  input wire logic SEQ_DONE,
  input wire logic SUSPEND_STATE,
  input wire logic MAIN_POWER_GOOD,
  input wire logic BACKUP_POWER_GOOD,
  input wire logic POWER_DOWN_REQ,
  input wire logic [4:0] RAIL_EN,
  input wire logic [2:0] SW_ON
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // pin inputs pass two sync stages, so a level held four edges must show
  a_backup_good_and: assert property ((BACKUP_A_GOOD && BACKUP_B_GOOD && !BIAS_LOW) [*4] |=> BACKUP_POWER_GOOD)
    else $error("backup good not high with both backups good");
  a_backup_bad_low: assert property ((!BACKUP_A_GOOD || !BACKUP_B_GOOD) [*4] |=> !BACKUP_POWER_GOOD)
    else $error("backup good high with a backup rail bad");
  a_all_off_low: assert property (RAIL_EN == 5'h00 |=> !MAIN_POWER_GOOD)
    else $error("main good high with every rail off");
  a_powerdown_low: assert property (POWER_DOWN_REQ |=> !MAIN_POWER_GOOD)
    else $error("main good high during power-down");
  a_suspend_low: assert property (SUSPEND_STATE [*3] |-> !MAIN_POWER_GOOD)
    else $error("main good high in suspend");
  a_good_after_done: assert property ($rose(MAIN_POWER_GOOD) |-> SEQ_DONE && $past(SEQ_DONE, 2))
    else $error("main good released before sequencer done");
  a_hot_switch_off: assert property (SW_OVERTEMP[1] [*4] |=> !SW_ON[1])
    else $error("hot switch left on");
  a_low_input_off: assert property (SW2_IN_LOW [*4] |=> !SW_ON[1])
    else $error("five-volt switch on with low input");
  a_bias_all_off: assert property (BIAS_LOW [*4] |=> RAIL_EN == 5'h00)
    else $error("rails on with bias low");
  a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged next cycle");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  // main scenarios seen at least once
  c_good_up: cover property ($rose(MAIN_POWER_GOOD));
  c_powerdown: cover property ($rose(POWER_DOWN_REQ));
  c_backup_drop: cover property ($fell(BACKUP_POWER_GOOD));
endmodule // pgls_ctrl_checker
bind pgls_ctrl pgls_ctrl_checker chk (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .BACKUP_A_GOOD(BACKUP_A_GOOD), .BACKUP_B_GOOD(BACKUP_B_GOOD), .BIAS_LOW(BIAS_LOW),
  .SW_OVERTEMP(SW_OVERTEMP), .SW2_IN_LOW(SW2_IN_LOW), .SEQ_DONE(SEQ_DONE), .SUSPEND_STATE(SUSPEND_STATE),
  .MAIN_POWER_GOOD(MAIN_POWER_GOOD), .BACKUP_POWER_GOOD(BACKUP_POWER_GOOD), .POWER_DOWN_REQ(POWER_DOWN_REQ),
  .RAIL_EN(RAIL_EN), .SW_ON(SW_ON));
`default_nettype wire

// ===== test/pgls_rail_model.sv
// model of the supervised rails: ramp after enable, injectable faults
`default_nettype none
module pgls_rail_model (
  input wire logic CLK,
  input wire logic [4:0] RAIL_EN,
  input wire logic [4:0] FAULT,
  output logic [4:0] RAIL_UV
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] ramp_reg [0:3];
  // a rail reads low until enabled for four cycles; off rails read low too
  always_ff @(posedge CLK) begin
    ramp_reg[0] <= RAIL_EN;
    for (int i = 1; i < 4; i++) ramp_reg[i] <= ramp_reg[i-1] & RAIL_EN;
  end
  assign RAIL_UV = ~ramp_reg[3] | FAULT;
endmodule // pgls_rail_model
`default_nettype wire

// ===== test/pgls_ctrl_tb_top.sv
// self-checking bench for the power-good and load switch block
`default_nettype none
module pgls_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, wsel = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic [4:0] fault = 5'h00, ov = 5'h00, rail_uv, rail_en, rail_dis;
  logic bk_a = 1'b1, bk_b = 1'b1, sw2_low = 1'b0, pf = 1'b0, uvlo = 1'b0, bias = 1'b0;
  logic seq_done = 1'b0, seq_stb = 1'b0, seq_en = 1'b0, sw1_en = 1'b0, sw1_stb = 1'b0, susp = 1'b0;
  logic [2:0] sw_lim = 3'h0, sw_hot = 3'h0, sw_on, sw_dis;
  logic mpg, bpg, pdr, core_rst, seq_rdy;
  logic [1:0] lim2, lim3;
  int mismatches = 0;
  int n_checks = 0;
  // short counts keep the run brief; every expectation below uses 20 except the fixed 500-cycle tight deglitch
  pgls_ctrl #(.MON_START(20), .STROBE_EXTRA(20), .UV_LOOSE(20), .DIP_WINDOW(20), .RELEASE_UNIT(20)) uut (
    .CLK(clk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .RAIL_UV(rail_uv), .RAIL_OV(ov),
    .BACKUP_A_GOOD(bk_a), .BACKUP_B_GOOD(bk_b), .SW_LIMITING(sw_lim), .SW_OVERTEMP(sw_hot),
    .SW2_IN_LOW(sw2_low), .POWERFAIL_TRIP(pf), .UVLO_TRIP(uvlo), .BIAS_LOW(bias), .SEQ_DONE(seq_done),
    .SEQ_RAIL_STROBE(seq_stb), .SEQ_RAIL_EN(seq_en), .SEQ_SW1_EN(sw1_en), .SEQ_SW1_STROBE(sw1_stb),
    .SUSPEND_STATE(susp), .MAIN_POWER_GOOD(mpg), .BACKUP_POWER_GOOD(bpg), .POWER_DOWN_REQ(pdr),
    .CORE_RESET(core_rst), .SEQ_STROBE_READY(seq_rdy), .RAIL_EN(rail_en), .RAIL_DISCHARGE(rail_dis), .SW_ON(sw_on),
    .SW_DISCHARGE(sw_dis), .SW2_LIMIT(lim2), .SW3_LIMIT(lim3));
  pgls_rail_model rails (.CLK(clk), .RAIL_EN(rail_en), .FAULT(fault), .RAIL_UV(rail_uv));
  always #50 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one classic cycle; entered just after an edge, holds until ack is sampled
  // a slave that never answers is caught by the watchdog, not here
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    sel <= wsel;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    check(n, q, e);
  endtask
  task automatic seq_pulse(input logic en);
    seq_en <= en;
    seq_stb <= 1'b1;
    @(posedge clk);
    seq_stb <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    step(5000);
    mismatches++;
    end_sim();
  end
  initial begin
    step(6);
    rstn <= 1'b1;
    check("good at reset", mpg, 0);
    check("core reset idle", core_rst, 0);
    rdc("enable reset", pgls_pkg::OFF_ENABLE, pgls_pkg::RST_ENABLE);
    rdc("swcfg reset", pgls_pkg::OFF_SWCFG, pgls_pkg::RST_SWCFG);
    rdc("supcfg reset", pgls_pkg::OFF_SUPCFG, pgls_pkg::RST_SUPCFG);
    rdc("unmapped", 8'h1C, pgls_pkg::BAD_ADDR_DATA);
    $display("test reset done");
    // release waits one unit of 20 cycles after the sequencer is done
    seq_pulse(1'b1);
    step(10);
    seq_done <= 1'b1;
    step(10);
    check("good early", mpg, 0);
    check("strobe ready early", seq_rdy, 0);
    step(30);
    check("good released", mpg, 1);
    check("strobe ready", seq_rdy, 1);
    bk_a <= 1'b0;
    step(6);
    check("backup good", bpg, 0);
    check("good on backup fault", mpg, 1);
    bk_a <= 1'b1;
    bk_b <= 1'b0;
    step(6);
    check("backup b", bpg, 0);
    check("good on backup b fault", mpg, 1);
    bk_b <= 1'b1;
    step(6);
    check("backup back", bpg, 1);
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0003);
    step(30);
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0001);
    step(5);
    check("good after rail off", mpg, 1);
    // a glitch shorter than the deglitch time must be forgotten
    fault <= 5'h01;
    step(12);
    fault <= 5'h00;
    step(4);
    fault <= 5'h01;
    step(12);
    fault <= 5'h00;
    step(10);
    check("good after glitch", mpg, 1);
    susp <= 1'b1;
    step(4);
    check("good in suspend", mpg, 0);
    susp <= 1'b0;
    fault <= 5'h01;
    step(30);
    check("powerdown on fault", pdr, 1);
    check("good on fault", mpg, 0);
    fault <= 5'h00;
    seq_done <= 1'b0;
    seq_pulse(1'b0);
    step(4);
    check("rails cleared", rail_en, 0);
    check("good all off", mpg, 0);
    $display("test power good done");
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0001);
    uvlo <= 1'b1;
    step(10);
    uvlo <= 1'b0;
    step(5);
    check("short dip", pdr, 0);
    uvlo <= 1'b1;
    step(30);
    check("long dip", pdr, 1);
    uvlo <= 1'b0;
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0000);
    $display("test lockout done");
    // overvoltage only counts in tight mode, with its own deglitch
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0001);
    step(30);
    ov <= 5'h01;
    step(30);
    check("overvoltage loose", pdr, 0);
    wr(pgls_pkg::OFF_SUPCFG, 32'h0000_0011);
    step(520);
    check("overvoltage tight", pdr, 1);
    ov <= 5'h00;
    wr(pgls_pkg::OFF_SUPCFG, 32'h0000_0010);
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0000);
    $display("test tight done");
    for (int k = 0; k < 4; k++) begin
      wr(pgls_pkg::OFF_SWCFG, (k << 8) | ((3 - k) << 10) | 32'h0000_0002);
      check("limit two", lim2, k);
      check("limit three", lim3, 3 - k);
    end
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0500);
    step(4);
    check("switch on", sw_on, 3'b101);
    check("switch discharge", sw_dis, 3'b010);
    sw1_en <= 1'b0;
    sw1_stb <= 1'b1;
    step(1);
    sw1_stb <= 1'b0;
    step(3);
    check("sequencer switch", sw_on, 3'b100);
    sw1_en <= 1'b1;
    sw1_stb <= 1'b1;
    step(1);
    sw1_stb <= 1'b0;
    step(3);
    check("sequencer switch on", sw_on, 3'b101);
    wr(pgls_pkg::OFF_SWCFG, 32'h0000_0040);
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0700);
    pf <= 1'b1;
    step(5);
    pf <= 1'b0;
    step(5);
    check("shed switch", sw_on, 3'b011);
    rdc("shed enable", pgls_pkg::OFF_ENABLE, 32'h0000_0300);
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0700);
    step(4);
    check("switch back", sw_on, 3'b111);
    // a write without its low byte lane selected is ignored
    wsel = 4'h0;
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0000);
    wsel = 4'hf;
    rdc("masked write", pgls_pkg::OFF_ENABLE, 32'h0000_0700);
    $display("test switches done");
    sw_lim <= 3'b001;
    step(6);
    check("limiting on", sw_on, 3'b111);
    sw_lim <= 3'b000;
    sw_hot <= 3'b010;
    step(6);
    check("hot off", sw_on, 3'b101);
    rdc("flags", pgls_pkg::OFF_IRQ, 32'h0000_0021);
    sw_hot <= 3'b000;
    step(6);
    check("cooled", sw_on, 3'b111);
    rdc("flags kept", pgls_pkg::OFF_IRQ, 32'h0000_0021);
    wr(pgls_pkg::OFF_IRQ, 32'h0000_0021);
    rdc("flags cleared", pgls_pkg::OFF_IRQ, 32'h0000_0000);
    sw2_low <= 1'b1;
    step(6);
    check("low input off", sw_on, 3'b101);
    sw2_low <= 1'b0;
    rdc("low input flag", pgls_pkg::OFF_IRQ, 32'h0000_0020);
    $display("test flags done");
    // bias loss last: the core stays in reset and the run ends there
    wr(pgls_pkg::OFF_ENABLE, 32'h0000_0001);
    step(6);
    bias <= 1'b1;
    step(6);
    check("bias rails", rail_en, 0);
    check("bias discharge", rail_dis, 5'h1f);
    check("bias core reset", core_rst, 1);
    $display("test bias done");
    end_sim();
  end
endmodule // pgls_ctrl_tb_top
`default_nettype wire
